// file: inc/uep_pkg.sv
package uep_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int PULSE_NOM_US = 50000;
  localparam int PULSE_MIN_US = 45000;
  localparam int PULSE_MAX_US = 55000;
  localparam int SETUP_US = 2;
  localparam int HOLD_US = 2;
  localparam int ACCESS_NS = 450;
  localparam int PULSE_CYC = (PULSE_NOM_US * 1000) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // commands
  // ----------------------------------------
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_PROGRAM = 2'h1;
  localparam logic [1:0] CMD_VERIFY = 2'h2;
  localparam logic [1:0] CMD_POWERDOWN = 2'h3;
  typedef enum logic [2:0] {
    UEP_IDLE, UEP_SETUP, UEP_PULSE, UEP_HOLD, UEP_ACCESS, UEP_PDOWN
  } uep_state_e;
endpackage

// file: logic/uep_host.sv
`timescale 1ns/1ps
// Operation
// - read: chip select low, strobe low, supply 5 V; device drives byte
// - programming: supply 25 V, chip select high, host drives data
// - one strobe high pulse per location, 45 to 55 ms, nominal 50
// - locations may be programmed in any order
// - 25 V, strobe low, chip select high: inhibited, pins float
// - verify: strobe and chip select low, device outputs stored byte
// - verify allowed any time, also right after a program pulse
// - parallel devices: per-device select and strobe choose who programs
module uep_host #(
  parameter int PULSE_CYCLES = uep_pkg::PULSE_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // command port
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd,
  input wire logic [uep_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic [uep_pkg::DATA_W-1:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [uep_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_rsp_match,
  output logic o_rsp_bad_request,
  // device pins
  output logic [uep_pkg::ADDR_W-1:0] o_addr,
  output logic o_chip_select_b,
  output logic o_powerdown_program_strobe,
  output logic o_vpp_high,
  output logic [uep_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic [uep_pkg::DATA_W-1:0] i_data
);
  typedef struct packed {
    uep_pkg::uep_state_e state;
    logic [31:0] cnt;
    logic [1:0] cmd;
    logic [uep_pkg::ADDR_W-1:0] addr;
    logic [uep_pkg::DATA_W-1:0] wdata;
    logic cs_b;
    logic strobe;
    logic vpp;
    logic oe;
    logic rsp_valid;
    logic [uep_pkg::DATA_W-1:0] rsp_data;
    logic rsp_match;
    logic rsp_bad;
    logic [uep_pkg::DATA_W-1:0] sync1;
    logic [uep_pkg::DATA_W-1:0] sync2;
  } uep_host_s;

  uep_host_s r;
  uep_host_s next_r;
  logic [31:0] pulse_last;

  assign pulse_last = PULSE_CYCLES - 1;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.sync1 = i_data;
    next_r.sync2 = r.sync1;
    case (r.state)
      uep_pkg::UEP_IDLE, uep_pkg::UEP_PDOWN: begin
        if (i_cmd_valid) begin
          next_r.cmd = i_cmd;
          next_r.addr = i_cmd_addr; // any address order
          next_r.wdata = i_cmd_data;
          next_r.cnt = 32'h0000_0000;
          case (i_cmd)
            uep_pkg::CMD_PROGRAM: begin
              if (r.vpp && !r.cs_b) begin
                // leaving verify at 25 V: deselect first; the lines below set oe again in the same cycle
                next_r.cs_b = 1'b1;
                next_r.oe = 1'b0;
              end
              // supply up, select high, strobe low: inhibited until pulse
              next_r.vpp = 1'b1;
              next_r.cs_b = 1'b1;
              next_r.strobe = 1'b0;
              next_r.oe = 1'b1;
              next_r.state = uep_pkg::UEP_SETUP;
            end
            uep_pkg::CMD_POWERDOWN: begin
              // strobe high, supply low, pins released
              next_r.vpp = 1'b0;
              next_r.strobe = 1'b1;
              next_r.cs_b = 1'b1;
              next_r.oe = 1'b0;
              next_r.state = uep_pkg::UEP_PDOWN;
            end
            default: begin
              // read at 5 V, verify keeps supply as it is
              if (i_cmd == uep_pkg::CMD_READ) begin
                next_r.vpp = 1'b0;
              end
              next_r.strobe = 1'b0;
              next_r.cs_b = 1'b0;
              next_r.oe = 1'b0;
              next_r.state = uep_pkg::UEP_ACCESS;
            end
          endcase
        end
      end
      uep_pkg::UEP_SETUP: begin
        next_r.cnt = r.cnt + 32'h0000_0001;
        if (r.cnt == uep_pkg::SETUP_CYC - 1) begin
          next_r.cnt = 32'h0000_0000;
          next_r.strobe = 1'b1; // program pulse starts
          next_r.state = uep_pkg::UEP_PULSE;
        end
      end
      uep_pkg::UEP_PULSE: begin
        next_r.cnt = r.cnt + 32'h0000_0001;
        if (r.cnt == pulse_last) begin
          next_r.cnt = 32'h0000_0000;
          next_r.strobe = 1'b0; // single pulse per location
          next_r.state = uep_pkg::UEP_HOLD;
        end
      end
      uep_pkg::UEP_HOLD: begin
        next_r.cnt = r.cnt + 32'h0000_0001;
        if (r.cnt == uep_pkg::HOLD_CYC - 1) begin
          next_r.oe = 1'b0; // back to inhibit, data released
          next_r.rsp_valid = 1'b1;
          next_r.rsp_data = r.wdata;
          next_r.rsp_match = 1'b1;
          next_r.rsp_bad = 1'b0;
          next_r.state = uep_pkg::UEP_IDLE;
        end
      end
      uep_pkg::UEP_ACCESS: begin
        next_r.cnt = r.cnt + 32'h0000_0001;
        // wait access time plus two synchroniser stages
        if (r.cnt == uep_pkg::ACCESS_CYC + 1) begin
          next_r.rsp_valid = 1'b1;
          next_r.rsp_data = r.sync2;
          next_r.rsp_match = (r.sync2 == r.wdata);
          // a 0 where a 1 is wanted needs an erase, another pulse cannot help
          next_r.rsp_bad = (r.cmd == uep_pkg::CMD_VERIFY) && ((~r.sync2 & r.wdata) != 8'h00);
          next_r.cs_b = 1'b1; // deselect so bus is free
          next_r.state = uep_pkg::UEP_IDLE;
        end
      end
      default: begin
        next_r.state = uep_pkg::UEP_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
      r.state <= uep_pkg::UEP_IDLE;
      r.cs_b <= 1'b1;
      r.wdata <= uep_pkg::ERASED_BYTE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_cmd_ready = (r.state == uep_pkg::UEP_IDLE) || (r.state == uep_pkg::UEP_PDOWN);
  assign o_rsp_valid = r.rsp_valid;
  assign o_rsp_data = r.rsp_data;
  assign o_rsp_match = r.rsp_match;
  assign o_rsp_bad_request = r.rsp_bad;
  assign o_addr = r.addr;
  assign o_chip_select_b = r.cs_b; // per-device select decides programming
  assign o_powerdown_program_strobe = r.strobe;
  assign o_vpp_high = r.vpp;
  assign o_data = r.wdata;
  assign o_data_oe = r.oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PULSE_LEN: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(r.strobe) && r.vpp |-> r.strobe [*8])
    else $error("program pulse ended early");
  AST_PROG_PINS: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.strobe && r.vpp |-> r.cs_b && r.oe)
    else $error("program pulse without select high and data driven");
  AST_READ_PINS: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.state == uep_pkg::UEP_ACCESS |-> !r.cs_b && !r.strobe && !r.oe)
    else $error("access without select and strobe low");
  AST_NO_CONTEND: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !r.cs_b |-> !r.oe)
    else $error("host drives data while device selected");
  AST_PDOWN: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.state == uep_pkg::UEP_PDOWN |-> r.strobe && !r.vpp && !r.oe)
    else $error("power down pins wrong");
  AST_INHIBIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.state == uep_pkg::UEP_SETUP |-> !r.strobe && r.cs_b && r.vpp)
    else $error("setup not in inhibit state");
  AST_ACC_DONE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(r.state == uep_pkg::UEP_ACCESS) |-> ##[13:14] r.rsp_valid)
    else $error("access answer late");
  AST_RELEASE: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.rsp_valid && r.state == uep_pkg::UEP_IDLE |-> r.cs_b)
    else $error("device still selected after answer");
  AST_READ_5V: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.state == uep_pkg::UEP_ACCESS && r.cmd == uep_pkg::CMD_READ |-> !r.vpp)
    else $error("read with programming supply raised");
  AST_BAD_VERIFY: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    r.rsp_valid && r.rsp_bad |-> r.cmd == uep_pkg::CMD_VERIFY)
    else $error("unfixable flag outside verify");
endmodule

// file: tb/uep_dev_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// memory device seen by the host
// ----------------------------------------
module uep_dev_model #(
  parameter int MIN_NS = 720,
  parameter int MAX_NS = 880
) (
  // device pins
  input wire logic [uep_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_cs_b,
  input wire logic i_pd,
  input wire logic i_vpp,
  input wire logic [7:0] i_q,
  // data drive and status
  output logic [7:0] o_q,
  output logic o_q_oe,
  output logic o_width_bad
);
  logic [7:0] mem [0:2047];
  logic rd_en;
  realtime t_rise;
  realtime t_chg;
  realtime t_due;
  // erased array reads all ones
  initial begin
    foreach (mem[k]) mem[k] = 8'hFF;
    o_width_bad = 1'b0;
    t_rise = 0;
  end
  // any move of select, power or address restarts the access time
  always @(i_cs_b or i_pd or i_addr) begin
    rd_en = 1'b0;
    t_chg = $realtime;
    t_due <= #(uep_pkg::ACCESS_NS) $realtime;
  end
  // data turns valid only if nothing moved during the access time
  always @(t_due) rd_en = (t_due == t_chg);
  assign o_q_oe = rd_en && !i_cs_b && !i_pd;
  // floating pins show inverted data so stale samples fail
  assign o_q = o_q_oe ? mem[i_addr] : ~mem[i_addr];
  // store on the falling edge of a pulse under high supply and high select
  always @(posedge i_pd) t_rise = $realtime;
  always @(negedge i_pd) begin
    if (i_vpp && i_cs_b) begin
      if ($realtime - t_rise < MIN_NS || $realtime - t_rise > MAX_NS) o_width_bad = 1'b1;
      mem[i_addr] = mem[i_addr] & i_q;
    end
  end
endmodule

// file: tb/test_uv_eprom_read_program_port.sv
`timescale 1ns/1ps
// ----------------------------------------
// host controller bench
// ----------------------------------------
module test_uv_eprom_read_program_port;
  localparam int PULSE = 20;
  localparam int PL = uep_pkg::SETUP_CYC + PULSE + uep_pkg::HOLD_CYC;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [1:0] i_cmd = 2'h0;
  logic [10:0] i_cmd_addr = 11'h0000;
  logic [7:0] i_cmd_data = 8'h00;
  logic ready, rsp_v, match, bad, cs_b, pd, vpp, oe, q_oe, w_bad;
  logic [7:0] rsp_d, d_out, q;
  logic [10:0] addr;
  wire [7:0] bus = oe ? d_out : q;
  int miscompares = 0;
  int n_checks = 0;
  always #20 i_core_clk = ~i_core_clk;
  uep_host #(.PULSE_CYCLES(PULSE)) dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
    .o_cmd_ready(ready), .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d), .o_rsp_match(match),
    .o_rsp_bad_request(bad), .o_addr(addr), .o_chip_select_b(cs_b),
    .o_powerdown_program_strobe(pd), .o_vpp_high(vpp), .o_data(d_out), .o_data_oe(oe),
    .i_data(bus));
  uep_dev_model #(.MIN_NS(PULSE * 36), .MAX_NS(PULSE * 44)) dev (.i_addr(addr), .i_cs_b(cs_b),
    .i_pd(pd), .i_vpp(vpp), .i_q(bus), .o_q(q), .o_q_oe(q_oe), .o_width_bad(w_bad));
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one command: pin levels three cycles in (not for verify), answer latency and contents
  task automatic run(input logic [1:0] c, input logic [10:0] a, input logic [7:0] d,
    input logic [7:0] lat, input logic [9:0] exp);
    int n;
    i_cmd <= c;
    i_cmd_addr <= a;
    i_cmd_data <= d;
    i_cmd_valid <= 1'b1;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b0;
    for (n = 1; n < 300; n++) begin
      @(posedge i_core_clk);
      if (n == 3 && c != uep_pkg::CMD_VERIFY) begin
        check("pins", {7'h0, {3{c[0]}}}, {7'h0, vpp, cs_b, oe});
      end
      if (rsp_v === 1'b1) break;
    end
    check("latency", {2'h0, lat}, {2'h0, 8'(n - 1)});
    check("answer", exp, {match, bad, rsp_d});
  endtask
  task automatic t_reset;
    repeat (5) @(posedge i_core_clk);
    check("reset pins", 10'h018, {5'h0, ready, cs_b, pd, vpp, oe});
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
  endtask
  task automatic t_prog_verify;
    run(uep_pkg::CMD_READ, 11'h0123, 8'hFF, 14, 10'h2FF);
    run(uep_pkg::CMD_PROGRAM, 11'h07FF, 8'h5A, PL, 10'h25A);
    run(uep_pkg::CMD_VERIFY, 11'h07FF, 8'h5A, 14, 10'h25A);
    check("pulse width", 10'h000, {9'h0, w_bad});
  endtask
  task automatic t_any_order;
    run(uep_pkg::CMD_PROGRAM, 11'h0003, 8'h0F, PL, 10'h20F);
    run(uep_pkg::CMD_PROGRAM, 11'h0001, 8'hF0, PL, 10'h2F0);
    run(uep_pkg::CMD_READ, 11'h0001, 8'hF0, 14, 10'h2F0);
    run(uep_pkg::CMD_READ, 11'h0003, 8'hFF, 14, 10'h00F);
  endtask
  task automatic t_no_clear;
    run(uep_pkg::CMD_PROGRAM, 11'h07FF, 8'hFF, PL, 10'h2FF);
    run(uep_pkg::CMD_VERIFY, 11'h07FF, 8'hFF, 14, 10'h15A);
  endtask
  task automatic t_powerdown;
    i_cmd <= uep_pkg::CMD_POWERDOWN;
    i_cmd_valid <= 1'b1;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b0;
    repeat (20) begin
      @(posedge i_core_clk);
      if (rsp_v !== 1'b0) check("no answer", 10'h000, 10'h001);
    end
    check("sleep pins", 10'h01C, {5'h0, ready, cs_b, pd, vpp, oe});
    run(uep_pkg::CMD_READ, 11'h0001, 8'hF0, 14, 10'h2F0);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_prog_verify();
    t_any_order();
    t_no_clear();
    t_powerdown();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    miscompares++;
    give_verdict();
  end
endmodule
